// ---- core/stbr_params.svh ----
// stbr_params.svh: register indices, reset values and field positions
// assumes: included by bare name from files under core/
`ifndef STBR_PARAMS_SVH
`define STBR_PARAMS_SVH

// register indices (byte address is four times the index)
`define STBR_IDX_W          6
`define STBR_IDX_DIAG       6'h06
`define STBR_IDX_CMD        6'h07
`define STBR_IDX_TYPE       6'h08
`define STBR_IDX_FWVER      6'h09
`define STBR_IDX_MUXSR      6'h0a
`define STBR_IDX_CHAN       6'h0b
`define STBR_IDX_MINLEN     6'h0c
`define STBR_IDX_DSTRUCT    6'h0d
`define STBR_IDX_ALIGN      6'h0f
`define STBR_IDX_HWVER      6'h10
`define STBR_IDX_CODE       6'h1f
`define STBR_IDX_FEATURE    6'h20
`define STBR_IDX_BAUD       6'h21
`define STBR_IDX_RCVTO      6'h22
`define STBR_IDX_TRSTO      6'h23
`define STBR_IDX_LAST_RW    6'h2f
`define STBR_IDX_MODE       6'h30

// reset values and read-only fixed values
`define STBR_RST_ZERO       16'h0000
`define STBR_VAL_MUXSR      16'h0218
`define STBR_VAL_CHAN       16'h0130
`define STBR_VAL_MINLEN     16'h3030
`define STBR_VAL_DSTRUCT    16'h0000
`define STBR_RST_FEATURE    16'h0007
`define STBR_RST_BAUD       16'h0003
`define STBR_RST_RCVTO      16'h0014
`define STBR_RST_TRSTO      16'h0014

// image mode register fields
`define STBR_MODE_W         3
`define STBR_MODE_COMPLETE  0
`define STBR_MODE_BIGEND    1
`define STBR_MODE_WALIGN    2
`define STBR_RST_MODE       3'h1

// address decode
`define STBR_ADDR_HI_ZERO   24'h000000

`endif

// ---- core/stbr_pkg.sv ----
// stbr_pkg: shared types of the terminal image and register block
// assumes: nothing beyond a SystemVerilog compiler
package stbr_pkg;

    // what sits in one byte slot of the process image
    typedef enum logic [2:0]
    {
        LANE_CTRL,
        LANE_D0,
        LANE_D1,
        LANE_D2,
        LANE_D3,
        LANE_D4,
        LANE_PAD
    } stbr_lane_t;

endpackage

// ---- core/stbr_lane_map.sv ----
// stbr_lane_map: works out which byte occupies each process image slot
// assumes: mode bits are stable flops of the same clock; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "stbr_params.svh"

module stbr_lane_map #(
    parameter int SLOTS = 8                          // image bytes
) (
    input  wire logic [`STBR_MODE_W-1:0] mode,        // image mode bits
    output stbr_pkg::stbr_lane_t          lane [SLOTS] // slot contents
);

    ////////////////////////////////////////////////////////////////////////
    // slot placement
    ////////////////////////////////////////////////////////////////////////

    // walk the slots in order; a pad keeps words on a boundary
    always_comb
    begin
        int  pos;
        logic be;
        logic wa;
        pos = 0;
        be  = mode[`STBR_MODE_BIGEND];
        wa  = mode[`STBR_MODE_WALIGN];
        for (int i = 0; i < SLOTS; i++)
        begin
            lane[i] = stbr_pkg::LANE_PAD;
        end
        if (mode[`STBR_MODE_COMPLETE])
        begin
            lane[0] = stbr_pkg::LANE_CTRL;
            pos     = wa ? 2 : 1;
        end
        // first word: d0/d1, swapped when big-endian
        if (wa && pos[0])
        begin
            pos = pos + 1;
        end
        lane[pos]     = be ? stbr_pkg::LANE_D1 : stbr_pkg::LANE_D0;
        lane[pos + 1] = be ? stbr_pkg::LANE_D0 : stbr_pkg::LANE_D1;
        pos = pos + 2;
        // odd byte d2 sits low, high half padded when aligned
        lane[pos] = stbr_pkg::LANE_D2;
        pos = wa ? pos + 2 : pos + 1;
        // last word: d3/d4
        lane[pos]     = be ? stbr_pkg::LANE_D4 : stbr_pkg::LANE_D3;
        lane[pos + 1] = be ? stbr_pkg::LANE_D3 : stbr_pkg::LANE_D4;
    end

endmodule // stbr_lane_map

`default_nettype wire

// ---- core/stbr_image_regs.sv ----
// stbr_image_regs: process image mapping and register bank of the terminal
// assumes: AHB-Lite single word transfers on hclk; link side bytes come
// from logic on the same clock, so no synchronisers are needed there
// limitation: hsize is not decoded, so any write acts on the whole word
// limitation: a new mode retunes the slot map at the next edge, so one
// image may be mixed while the coupler and the terminal disagree
`timescale 1ns/1ps
`default_nettype none
`include "stbr_params.svh"

module stbr_image_regs #(
    parameter int             SLOTS     = 8,         // process image bytes
    parameter logic [15:0]    TYPE_ID   = 16'h0a5c,  // arbitrary type code
    parameter logic [15:0]    FW_VER    = 16'h0100,  // arbitrary version
    parameter logic [15:0]    HW_VER    = 16'h0001   // arbitrary version
) (
    input  wire logic               hclk,          // bus clock, 250 MHz
    input  wire logic               hresetn,       // async reset, low
    // ahb-lite slave
    input  wire logic               hsel,          // slave select
    input  wire logic [31:0]        haddr,         // byte address
    input  wire logic [1:0]         htrans,        // transfer type
    input  wire logic               hwrite,        // write when high
    input  wire logic [2:0]         hsize,         // word only
    input  wire logic [31:0]        hwdata,        // write data
    input  wire logic               hready,        // bus ready
    output logic                    hreadyout,     // never stalls
    output logic [31:0]             hrdata,        // read data
    output logic                    hresp,         // always okay
    // coupler process image
    input  wire logic [8*SLOTS-1:0] out_image,     // outputs from coupler
    output logic [8*SLOTS-1:0]      in_image,      // inputs to coupler
    // link side
    input  wire logic [39:0]        link_rx_data,  // received data bytes
    input  wire logic [7:0]         link_status,   // status byte source
    output logic [39:0]             link_tx_data,  // data bytes to send
    output logic [7:0]              link_control,  // control byte out
    output logic [15:0]             feature_word,  // feature setting
    output logic [15:0]             line_speed,    // baud rate code
    output logic [15:0]             rcv_timeout,   // receive timeout
    output logic [15:0]             trs_timeout    // transmit timeout
);

    // the writable span runs from the alignment word to the last spare
    localparam int RW_BASE = `STBR_IDX_ALIGN;      // first writable index
    localparam int RW_CNT  = `STBR_IDX_LAST_RW - `STBR_IDX_ALIGN + 1; // writable words

    ////////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////////

    // image side: slot map and mode word
    stbr_pkg::stbr_lane_t         lane [SLOTS];       // slot map
    logic [`STBR_MODE_W-1:0]      mode;               // image mode
    logic [`STBR_MODE_W-1:0]      next_mode;
    // bus side: storage and the pending write
    logic [15:0]                  bank [RW_CNT];      // writable words
    logic [15:0]                  next_bank [RW_CNT];
    logic                         wr_pend;            // write data phase
    logic                         next_wr_pend;
    logic [`STBR_IDX_W-1:0]       wr_idx;             // latched index
    logic [`STBR_IDX_W-1:0]       next_wr_idx;
    logic                         wr_ok;              // upper address was zero
    logic                         next_wr_ok;
    logic [31:0]                  next_hrdata;
    logic [8*SLOTS-1:0]           next_in_image;
    logic [39:0]                  next_link_tx;
    logic [7:0]                   next_link_ctrl;
    // diagnostic copy of the status byte
    logic [7:0]                   status_q;           // last status byte
    logic [7:0]                   next_status;
    // address phase decode, combinational
    logic                         addr_hit;           // valid address phase
    logic [`STBR_IDX_W-1:0]       a_idx;              // address phase index
    logic                         a_mapped;           // upper address zero

    // rw bank reset value for one index
    // hardware version is a parameter so each build carries its own
    function automatic logic [15:0] rw_reset(input int i);
        case (i + RW_BASE)
            `STBR_IDX_HWVER:   rw_reset = HW_VER;
            `STBR_IDX_FEATURE: rw_reset = `STBR_RST_FEATURE;
            `STBR_IDX_BAUD:    rw_reset = `STBR_RST_BAUD;
            `STBR_IDX_RCVTO:   rw_reset = `STBR_RST_RCVTO;
            `STBR_IDX_TRSTO:   rw_reset = `STBR_RST_TRSTO;
            default:           rw_reset = `STBR_RST_ZERO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // slot map
    ////////////////////////////////////////////////////////////////////////

    stbr_lane_map #(
        .SLOTS (SLOTS)
    ) u_lane_map (
        .mode  (mode),
        .lane  (lane)
    );

    ////////////////////////////////////////////////////////////////////////
    // ahb address phase decode
    ////////////////////////////////////////////////////////////////////////

    // zero wait states: the answer is always ready and okay
    // hresp stays low: no access here can fail
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_hit  = hsel && htrans[1] && hready;
    // byte address is four times the index; the two low bits are ignored
    assign a_idx     = haddr[`STBR_IDX_W+1:2];
    // any upper address bit set makes the access unmapped: it reads zero
    assign a_mapped  = (haddr[31:8] == `STBR_ADDR_HI_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // register bank and bus next state
    ////////////////////////////////////////////////////////////////////////

    // write lands in the data phase; read data is fetched in the address
    // phase so hrdata is a flop by the data phase
    // hazard: a read whose address phase overlaps a write's data phase
    // fetches the old word; a master that waits for each data phase
    // before the next address never meets this
    always_comb
    begin
        // address phase: remember where the data phase will go
        next_wr_pend = addr_hit && hwrite;
        next_wr_idx  = addr_hit ? a_idx : wr_idx;
        next_wr_ok   = addr_hit ? a_mapped : wr_ok;
        // every word holds unless a mapped write lands
        next_mode    = mode;
        for (int i = 0; i < RW_CNT; i++)
        begin
            next_bank[i] = bank[i];
        end
        if (wr_pend && wr_ok)
        begin
            // read-only indices quietly drop the write
            if (wr_idx == `STBR_IDX_MODE)
            begin
                next_mode = hwdata[`STBR_MODE_W-1:0];
            end
            // storage words, spares included
            else if (wr_idx >= 6'(RW_BASE) && wr_idx <= `STBR_IDX_LAST_RW)
            begin
                next_bank[wr_idx - 6'(RW_BASE)] = hwdata[15:0];
            end
        end
        // read mux: narrower words sit low, upper bits read as zero
        // unmapped words fall through to zero as well
        next_hrdata = hrdata;
        if (addr_hit && !hwrite)
        begin
            next_hrdata = 32'h00000000;
            if (a_mapped)
            begin
                case (a_idx)
                    `STBR_IDX_DIAG:    next_hrdata[15:0] = {link_control, status_q};
                    `STBR_IDX_CMD:     next_hrdata[15:0] = `STBR_RST_ZERO;
                    `STBR_IDX_TYPE:    next_hrdata[15:0] = TYPE_ID;
                    `STBR_IDX_FWVER:   next_hrdata[15:0] = FW_VER;
                    `STBR_IDX_MUXSR:   next_hrdata[15:0] = `STBR_VAL_MUXSR;
                    `STBR_IDX_CHAN:    next_hrdata[15:0] = `STBR_VAL_CHAN;
                    `STBR_IDX_MINLEN:  next_hrdata[15:0] = `STBR_VAL_MINLEN;
                    `STBR_IDX_DSTRUCT: next_hrdata[15:0] = `STBR_VAL_DSTRUCT;
                    `STBR_IDX_MODE:    next_hrdata[`STBR_MODE_W-1:0] = mode;
                    default:
                    begin
                        // writable bank, unused words included
                        if (a_idx >= 6'(RW_BASE) && a_idx <= `STBR_IDX_LAST_RW)
                        begin
                            next_hrdata[15:0] = bank[a_idx - 6'(RW_BASE)];
                        end
                    end
                endcase
            end
        end
    end

    // bus and bank flops
    // reset loads constants only: setting defaults, the parameter version and the mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_idx  <= '0;
            wr_ok   <= 1'b0;
            hrdata  <= 32'h00000000;
            mode    <= `STBR_RST_MODE;
            for (int i = 0; i < RW_CNT; i++)
            begin
                bank[i] <= rw_reset(i);
            end
        end
        else
        begin
            wr_pend <= next_wr_pend;
            wr_idx  <= next_wr_idx;
            wr_ok   <= next_wr_ok;
            hrdata  <= next_hrdata;
            mode    <= next_mode;
            for (int i = 0; i < RW_CNT; i++)
            begin
                bank[i] <= next_bank[i];
            end
        end
    end

    // settings that steer the serial side
    // fixed slots of the bank, read by the serial side every cycle
    assign feature_word = bank[`STBR_IDX_FEATURE - 6'(RW_BASE)];
    assign line_speed   = bank[`STBR_IDX_BAUD - 6'(RW_BASE)];
    assign rcv_timeout  = bank[`STBR_IDX_RCVTO - 6'(RW_BASE)];
    assign trs_timeout  = bank[`STBR_IDX_TRSTO - 6'(RW_BASE)];

    ////////////////////////////////////////////////////////////////////////
    // process image packing and unpacking
    ////////////////////////////////////////////////////////////////////////

    // inputs image is built from link bytes; outputs image is split back
    // into link bytes with the same slot map, so both directions mirror
    // in complete mode control byte and status byte share slot zero, one per direction
    always_comb
    begin
        // status copy for the diagnostic word, one edge late
        next_status    = link_status;
        next_in_image  = '0;
        next_link_tx   = '0;
        next_link_ctrl = 8'h00;
        for (int s = 0; s < SLOTS; s++)
        begin
            case (lane[s])
                stbr_pkg::LANE_CTRL:
                begin
                    next_in_image[8*s +: 8] = link_status;
                    next_link_ctrl          = out_image[8*s +: 8];
                end
                stbr_pkg::LANE_D0:
                begin
                    next_in_image[8*s +: 8] = link_rx_data[7:0];
                    next_link_tx[7:0]       = out_image[8*s +: 8];
                end
                stbr_pkg::LANE_D1:
                begin
                    next_in_image[8*s +: 8] = link_rx_data[15:8];
                    next_link_tx[15:8]      = out_image[8*s +: 8];
                end
                stbr_pkg::LANE_D2:
                begin
                    next_in_image[8*s +: 8] = link_rx_data[23:16];
                    next_link_tx[23:16]     = out_image[8*s +: 8];
                end
                stbr_pkg::LANE_D3:
                begin
                    next_in_image[8*s +: 8] = link_rx_data[31:24];
                    next_link_tx[31:24]     = out_image[8*s +: 8];
                end
                stbr_pkg::LANE_D4:
                begin
                    next_in_image[8*s +: 8] = link_rx_data[39:32];
                    next_link_tx[39:32]     = out_image[8*s +: 8];
                end
                default:
                begin
                    // pad slot stays zero toward the coupler
                    // and an outputs byte in a pad slot is dropped
                    next_in_image[8*s +: 8] = 8'h00;
                end
            endcase
        end
    end

    // image flops: one cycle from either source to its destination
    // a pad slot clears at reset like the data slots, so no stale byte
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            in_image     <= '0;
            link_tx_data <= 40'h0000000000;
            link_control <= 8'h00;
            status_q     <= 8'h00;
        end
        else
        begin
            in_image     <= next_in_image;
            link_tx_data <= next_link_tx;
            link_control <= next_link_ctrl;
            status_q     <= next_status;
        end
    end

endmodule // stbr_image_regs

`default_nettype wire

// ---- verification/stbr_image_regs_properties.sv ----
// stbr_image_regs_properties.sv: port-level checks of the image/register block
// assumes: bound into stbr_image_regs; mode bits change only by bus writes
`timescale 1ns/1ps
`default_nettype none
module stbr_image_regs_checker #(
    parameter int SLOTS = 8                      // image bytes
) (
    input wire logic               hclk,         // bus clock
    input wire logic               hresetn,      // async reset, low
    input wire logic               hsel,         // slave select
    input wire logic [31:0]        haddr,        // byte address
    input wire logic [1:0]         htrans,       // transfer type
    input wire logic               hwrite,       // write when high
    input wire logic               hready,       // bus ready
    input wire logic [31:0]        hwdata,       // write data
    input wire logic [31:0]        hrdata,       // read data
    input wire logic [8*SLOTS-1:0] out_image,    // coupler outputs
    input wire logic [8*SLOTS-1:0] in_image,     // coupler inputs
    input wire logic [39:0]        link_rx_data, // received bytes
    input wire logic [7:0]         link_status,  // status source
    input wire logic [39:0]        link_tx_data, // bytes to send
    input wire logic [7:0]         link_control  // control byte out
);
    logic [2:0] mode_q;   // mirrored mode bits
    logic [2:0] mode_d;   // mirror one cycle back
    logic       wr_mode;  // mode write in its data phase
    logic [1:0] live;     // edges since reset, saturating
    logic       settled;  // mode steady long enough to judge the image
    assign settled = (mode_q == mode_d) && live[1];
    ////////////////////////////////////////////////////////////////////////
    // follow the mode register; data lands at the end of the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_q  <= 3'h1;
            mode_d  <= 3'h1;
            wr_mode <= 1'b0;
            live    <= 2'h0;
        end
        else
        begin
            wr_mode <= hsel && htrans[1] && hready && hwrite && haddr == 32'hc0;
            mode_q  <= wr_mode ? hwdata[2:0] : mode_q;
            mode_d  <= mode_q;
            live    <= live[1] ? live : live + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_cmd_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && htrans[1] && hready && !hwrite && haddr == 32'h1c |=> hrdata == 32'h0)
        else $error("command word did not read zero");
    a_status_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
        settled && mode_q[0] |-> in_image[7:0] == $past(link_status))
        else $error("status byte not in slot zero");
    a_data_plain: assert property (@(posedge hclk) disable iff (!hresetn)
        settled && mode_q == 3'h0 |-> in_image[39:0] == $past(link_rx_data))
        else $error("plain data bytes misplaced");
    a_bigend_swap: assert property (@(posedge hclk) disable iff (!hresetn)
        settled && mode_q == 3'h2 |-> in_image[15:0] == {$past(link_rx_data[7:0]),
        $past(link_rx_data[15:8])})
        else $error("big-endian pair not swapped");
    a_word_align: assert property (@(posedge hclk) disable iff (!hresetn)
        settled && mode_q == 3'h5 |-> in_image[15:8] == 8'h0
        && in_image[23:16] == $past(link_rx_data[7:0]))
        else $error("aligned data not on word boundary");
    a_control_out: assert property (@(posedge hclk) disable iff (!hresetn)
        settled |-> link_control == (mode_q[0] ? $past(out_image[7:0]) : 8'h0))
        else $error("control byte unpacked wrongly");
    a_tx_unpack: assert property (@(posedge hclk) disable iff (!hresetn)
        settled && mode_q == 3'h0 |-> link_tx_data == $past(out_image[39:0]))
        else $error("transmit bytes unpacked wrongly");
endmodule // stbr_image_regs_checker
bind stbr_image_regs stbr_image_regs_checker #(.SLOTS(SLOTS)) chk_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .out_image(out_image), .in_image(in_image), .link_rx_data(link_rx_data),
    .link_status(link_status), .link_tx_data(link_tx_data), .link_control(link_control));
`default_nettype wire

// ---- verification/stbr_coupler_model.sv ----
// stbr_coupler_model: bus coupler side, builds the output process image
// assumes: same clock as the terminal; mode matches the terminal's mode bits
`timescale 1ns/1ps
`default_nettype none
module stbr_coupler_model (
    input wire logic        hclk,      // clock
    input wire logic [2:0]  mode,      // complete, bigend, walign
    input wire logic [7:0]  ctrl,      // control byte to send
    input wire logic [39:0] data,      // data bytes zero..four
    output logic [63:0]     out_image  // output process image
);
    ////////////////////////////////////////////////////////////////////////
    // slot layout; pads stay zero so a stray lane shows up
    function automatic logic [63:0] map_image(input logic [2:0] m,
        input logic [39:0] d, input logic [7:0] c);
        logic [63:0] v;
        int          s;
        v = 64'h0;
        s = 0;
        if (m[0])
        begin
            v[7:0] = c;
            s = m[2] ? 2 : 1;
        end
        v[8*s+:16] = m[1] ? {d[7:0], d[15:8]} : d[15:0];
        s = s + 2;
        v[8*s+:8] = d[23:16];
        s = s + (m[2] ? 2 : 1);
        v[8*s+:16] = m[1] ? {d[31:24], d[39:32]} : d[39:24];
        return v;
    endfunction
    // image refreshed every cycle, like a continuously cycling coupler
    always_ff @(posedge hclk)
    begin
        out_image <= map_image(mode, data, ctrl);
    end
endmodule // stbr_coupler_model
`default_nettype wire

// ---- verification/test_serial_terminal_image_and_registers.sv ----
// test_serial_terminal_image_and_registers: self-checking bench
// assumes: zero-wait slave; coupler model on the same clock
`timescale 1ns/1ps
`default_nettype none
module test_serial_terminal_image_and_registers;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0]  htrans = 2'h0;       // transfer type
    logic [2:0]  hsize = 3'h2, p_mode = 3'h1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [63:0] out_image, in_image; // process images
    logic [39:0] rx = 40'h0, p_data = 40'h0, link_tx_data;
    logic [7:0]  st = 8'h0, p_ctrl = 8'h0, link_control;
    logic [15:0] feat, speed, rto, tto;
    int          errors = 0, comparisons = 0;
    logic [5:0]  ri [16] = '{6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
                             6'h10, 6'h20, 6'h21, 6'h22, 6'h23, 6'h0f, 6'h1f, 6'h30};
    logic [15:0] rv [16] = '{16'h0, 16'h0, 16'h1234, 16'h0203, 16'h0218, 16'h0130,
        16'h3030, 16'h0, 16'h0042, 16'h0007, 16'h0003, 16'h0014, 16'h0014, 16'h0, 16'h0, 16'h1};
    always #2 hclk = ~hclk;           // 250 MHz
    ////////////////////////////////////////////////////////////////////////
    stbr_image_regs #(.TYPE_ID(16'h1234), .FW_VER(16'h0203), .HW_VER(16'h0042)) // arbitrary codes
    stbr_image_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .out_image(out_image),
        .in_image(in_image), .link_rx_data(rx), .link_status(st), .link_tx_data(link_tx_data),
        .link_control(link_control), .feature_word(feat), .line_speed(speed),
        .rcv_timeout(rto), .trs_timeout(tto));
    stbr_coupler_model stbr_coupler_model_inst (.hclk(hclk), .mode(p_mode), .ctrl(p_ctrl),
        .data(p_data), .out_image(out_image));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // one single transfer; address held until ready, then data phase
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        // hsel stays up; htrans idle marks the gap between transfers
        chk("hresp", 64'h0, {63'h0, hresp});
    endtask
    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reset values of the bank and its output ports
    task automatic test_reset();
        logic [31:0] r;
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b0, {24'h0, ri[i], 2'h0}, 32'h0, r);
            chk("reset_reg", {48'h0, rv[i]}, {32'h0, r});
        end
        chk("bank_ports", 64'h0007_0003_0014_0014, {feat, speed, rto, tto});
    endtask
    // writes to read-only, unmapped and writable places, wide data
    task automatic test_writes();
        logic [31:0] r;
        logic [31:0] wa [8] = '{32'h1c, 32'h28, 32'h38, 32'h100, 32'h80, 32'h84, 32'h88, 32'h8c};
        logic [15:0] ev [8] = '{16'h0, 16'h0218, 16'h0, 16'h0, 16'hc3c4, 16'hc3c5,
                                16'hc3c6, 16'hc3c7};
        for (int i = 0; i < 8; i++)
            xfer(1'b1, wa[i], 32'hffff_c3c0 + i, r);
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b0, wa[i], 32'h0, r);
            chk("readback", {48'h0, ev[i]}, {32'h0, r});
        end
        chk("bank_ports", 64'hc3c4_c3c5_c3c6_c3c7, {feat, speed, rto, tto});
    endtask
    // every mode: image layout both ways and the diagnostic word
    task automatic test_modes();
        logic [31:0] r;
        logic [7:0]  c;
        for (int m = 0; m < 8; m++)
        begin
            xfer(1'b1, 32'hc0, m, r);
            xfer(1'b0, 32'hc0, 32'h0, r);
            chk("mode", m, {32'h0, r});
            c = 8'h80 | 8'(m);
            p_mode <= 3'(m);
            p_ctrl <= c;
            p_data <= 40'h44_33_22_11_00 + 40'(m);
            rx <= 40'hb4_b3_b2_b1_b0 + 40'(m);
            st <= 8'h50 + 8'(m);
            repeat (3) @(posedge hclk);
            chk("in_image", stbr_coupler_model_inst.map_image(3'(m), rx, st), in_image);
            chk("tx_data", {24'h0, p_data}, {24'h0, link_tx_data});
            c = m[0] ? c : 8'h0;
            chk("control", {56'h0, c}, {56'h0, link_control});
            xfer(1'b0, 32'h18, 32'h0, r);
            chk("diag", {48'h0, c, st}, {32'h0, r});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_writes();
        test_modes();
        report_and_stop();
    end
    // hang guard, well beyond the roughly 150 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge hclk);
        errors++;
        report_and_stop();
    end
endmodule // test_serial_terminal_image_and_registers
`default_nettype wire
